// *** hw/esb_consts.svh ***
`ifndef ESB_CONSTS_SVH
`define ESB_CONSTS_SVH

`define ESB_DEV_TYPE        4'hA
`define ESB_ADDR_W          8
`define ESB_DATA_W          8
`define ESB_CODE_W          12
`define ESB_MEM_WORDS       256
`define ESB_FIFO_W          16
`define ESB_FIFO_DEPTH      32
`define ESB_PAGE_BYTES      4'h8
`define ESB_BITS_PER_BYTE   4'h8
`define ESB_TYPE_MSB        7
`define ESB_TYPE_LSB        4
`define ESB_CS_MSB          3
`define ESB_CS_LSB          1
`define ESB_RW_BIT          0
`define ESB_CLK_HZ          10000000
`define ESB_SCL_MAX_KHZ     100
`define ESB_EW_BYTE_MS      10
`define ESB_EW_BYTE_CYCLES  ((`ESB_EW_BYTE_MS * `ESB_CLK_HZ) / 1000)
`define ESB_EXT_TICKS       1

`endif

// *** hw/esb_pkg.sv ***
`include "esb_consts.svh"

package esb_pkg;

	typedef enum logic [3:0] {
		ESB_IDLE,
		ESB_ADDR,
		ESB_ADDR_ACK,
		ESB_WADDR,
		ESB_WADDR_ACK,
		ESB_WDATA,
		ESB_WDATA_ACK,
		ESB_RDATA,
		ESB_RACK,
		ESB_IGNORE
	} esb_state_t;

	typedef struct packed {
		logic                                              scl_m;
		logic                                              scl_s;
		logic                                              scl_d;
		logic                                              sda_m;
		logic                                              sda_s;
		logic                                              sda_d;
		logic [2:0]                                        cs_m;
		logic [2:0]                                        cs_s;
		logic                                              prg_m;
		logic                                              prg_s;
		logic                                              prg_d;
		logic                                              ext_mode;
		esb_state_t                                        state;
		logic [3:0]                                        bitcnt;
		logic [7:0]                                        shreg;
		logic                                              rw;
		logic                                              mack;
		logic [`ESB_ADDR_W-1:0]                            waddr;
		logic [3:0]                                        nbytes;
		logic                                              ovf;
		logic                                              push;
		logic                                              flush;
		logic                                              sda_oe;
		logic                                              busy;
		logic [31:0]                                       ew_cnt;
		logic [`ESB_MEM_WORDS-1:0][`ESB_CODE_W-1:0]        mem;
	} esb_regs_t;

endpackage : esb_pkg

// *** hw/esb_fifo.sv ***
`timescale 1ns/1ps

module esb_fifo #(
	parameter int W     = 16,
	parameter int DEPTH = 32
) (
	input  wire logic         clk,
	input  wire logic         srst,
	input  wire logic         flush,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);

	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW-1:0]           wptr;
		logic [PW-1:0]           rptr;
		logic [PW:0]             count;
	} esb_fifo_regs_t;

	esb_fifo_regs_t r_reg;
	esb_fifo_regs_t r_next;
	logic           do_push;
	logic           do_pop;

	assign in_ready  = (r_reg.count != DEPTH[PW:0]);
	assign out_valid = (r_reg.count != '0);
	assign out_data  = r_reg.mem[r_reg.rptr];
	assign do_push   = in_valid & in_ready;
	assign do_pop    = out_valid & out_ready;

	// =====================================================
	// Next state
	always_comb begin
		r_next = r_reg;
		if (do_push) begin
			r_next.mem[r_reg.wptr] = in_data;
			r_next.wptr            = (r_reg.wptr == PW'(DEPTH - 1)) ? '0 : r_reg.wptr + PW'(1);
		end
		if (do_pop) begin
			r_next.rptr = (r_reg.rptr == PW'(DEPTH - 1)) ? '0 : r_reg.rptr + PW'(1);
		end
		r_next.count = r_reg.count + (PW+1)'(do_push) - (PW+1)'(do_pop);
		// Flush drops a rejected page outright
		if (flush) begin
			r_next.wptr  = '0;
			r_next.rptr  = '0;
			r_next.count = '0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

endmodule : esb_fifo

// *** hw/esb_serial_eeprom_bus_slave.sv ***
`timescale 1ns/1ps
`include "esb_consts.svh"

module esb_serial_eeprom_bus_slave #(
	parameter int unsigned EW_BYTE_CYCLES = `ESB_EW_BYTE_CYCLES,
	parameter int unsigned EXT_TICKS      = `ESB_EXT_TICKS,
	parameter int          FIFO_DEPTH     = `ESB_FIFO_DEPTH
) (
	input  wire logic CLK_SYS,
	input  wire logic SRST,
	input  wire logic SCL,
	input  wire logic SDA_I,
	output logic      SDA_O,
	output logic      SDA_OE,
	input  wire logic CHIP_SELECT_BIT0,
	input  wire logic CHIP_SELECT_BIT1,
	input  wire logic CHIP_SELECT_BIT2,
	input  wire logic PROG_TIMING_PIN,
	output logic      EW_BUSY
);

	// =====================================================
	// Single error correcting code
	function automatic logic [`ESB_CODE_W-1:0] esb_encode(input logic [`ESB_DATA_W-1:0] d);
		logic [`ESB_CODE_W-1:0] c;
		int                     k;
		c = '0;
		k = 0;
		for (int p = 1; p <= `ESB_CODE_W; p++) begin
			if ((p & (p - 1)) != 0) begin
				c[p-1] = d[k];
				k++;
			end
		end
		for (int b = 0; b < 4; b++) begin
			for (int p = 1; p <= `ESB_CODE_W; p++) begin
				if (((p >> b) & 1) == 1 && p != (1 << b)) begin
					c[(1<<b)-1] = c[(1<<b)-1] ^ c[p-1];
				end
			end
		end
		return c;
	endfunction : esb_encode

	function automatic logic [`ESB_DATA_W-1:0] esb_decode(input logic [`ESB_CODE_W-1:0] cin);
		logic [`ESB_CODE_W-1:0] c;
		logic [`ESB_DATA_W-1:0] d;
		int                     s;
		int                     k;
		c = cin;
		d = '0;
		s = 0;
		k = 0;
		for (int p = 1; p <= `ESB_CODE_W; p++) begin
			if (c[p-1]) begin
				s = s ^ p;
			end
		end
		if (s >= 1 && s <= `ESB_CODE_W) begin
			c[s-1] = ~c[s-1];
		end
		for (int p = 1; p <= `ESB_CODE_W; p++) begin
			if ((p & (p - 1)) != 0) begin
				d[k] = c[p-1];
				k++;
			end
		end
		return d;
	endfunction : esb_decode

	esb_pkg::esb_regs_t     r_reg;
	esb_pkg::esb_regs_t     r_next;
	logic                   fifo_ready;
	logic                   fifo_valid;
	logic                   fifo_pop;
	logic [`ESB_FIFO_W-1:0] fifo_out;
	logic                   scl_rise;
	logic                   scl_fall;
	logic                   start_cond;
	logic                   stop_cond;
	logic                   tick;
	logic                   addr_match;

	assign scl_rise   = r_reg.scl_s & ~r_reg.scl_d;
	assign scl_fall   = ~r_reg.scl_s & r_reg.scl_d;
	assign start_cond = r_reg.scl_s & r_reg.scl_d & r_reg.sda_d & ~r_reg.sda_s;
	assign stop_cond  = r_reg.scl_s & r_reg.scl_d & ~r_reg.sda_d & r_reg.sda_s;
	assign tick       = r_reg.ext_mode ? (r_reg.prg_s & ~r_reg.prg_d) : 1'b1;
	assign addr_match = (r_reg.shreg[`ESB_TYPE_MSB:`ESB_TYPE_LSB] == `ESB_DEV_TYPE)
		&& (r_reg.shreg[`ESB_CS_MSB:`ESB_CS_LSB] == r_reg.cs_s);
	assign fifo_pop   = r_reg.busy & fifo_valid & tick
		& (r_reg.ew_cnt >= (r_reg.ext_mode ? EXT_TICKS - 1 : EW_BYTE_CYCLES - 1));

	esb_fifo #(
		.W     (`ESB_FIFO_W),
		.DEPTH (FIFO_DEPTH)
	) u_page_fifo (
		.clk       (CLK_SYS),
		.srst      (SRST),
		.flush     (r_reg.flush),
		.in_valid  (r_reg.push),
		.in_ready  (fifo_ready),
		.in_data   ({r_reg.waddr, r_reg.shreg}),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_out)
	);

	// =====================================================
	// Next state
	always_comb begin
		r_next       = r_reg;
		r_next.push  = 1'b0;
		r_next.flush = 1'b0;
		r_next.scl_m = SCL;
		r_next.scl_s = r_reg.scl_m;
		r_next.scl_d = r_reg.scl_s;
		r_next.sda_m = SDA_I;
		r_next.sda_s = r_reg.sda_m;
		r_next.sda_d = r_reg.sda_s;
		r_next.cs_m  = {CHIP_SELECT_BIT2, CHIP_SELECT_BIT1, CHIP_SELECT_BIT0};
		r_next.cs_s  = r_reg.cs_m;
		r_next.prg_m = PROG_TIMING_PIN;
		r_next.prg_s = r_reg.prg_m;
		r_next.prg_d = r_reg.prg_s;
		// a falling edge means a driven clock
		if (r_reg.prg_d & ~r_reg.prg_s) begin
			r_next.ext_mode = 1'b1;
		end

		// Programming engine
		if (r_reg.busy) begin
			if (fifo_pop) begin
				r_next.mem[fifo_out[15:8]] = esb_encode(fifo_out[7:0]);
				r_next.ew_cnt              = '0;
			end else if (!fifo_valid) begin
				r_next.busy   = 1'b0;
				r_next.ew_cnt = '0;
			end else if (tick) begin
				r_next.ew_cnt = r_reg.ew_cnt + 32'h1;
			end
		end

		if (start_cond || stop_cond) begin
			// commit collected bytes at end of transfer
			if (r_reg.nbytes != 4'h0 && !r_reg.ovf) begin
				r_next.busy = 1'b1;
			end else if (r_reg.ovf) begin
				r_next.flush = 1'b1;
			end
			r_next.nbytes = 4'h0;
			r_next.ovf    = 1'b0;
			r_next.bitcnt = 4'h0;
			r_next.sda_oe = 1'b0;
			r_next.state  = start_cond ? esb_pkg::ESB_ADDR : esb_pkg::ESB_IDLE;
		end else begin
			unique case (r_reg.state)
				esb_pkg::ESB_IDLE, esb_pkg::ESB_IGNORE: begin
					r_next.sda_oe = 1'b0;
				end
				esb_pkg::ESB_ADDR, esb_pkg::ESB_WADDR, esb_pkg::ESB_WDATA: begin
					if (scl_rise) begin
						r_next.shreg  = {r_reg.shreg[6:0], r_reg.sda_s};
						r_next.bitcnt = r_reg.bitcnt + 4'h1;
					end else if (scl_fall && r_reg.bitcnt == `ESB_BITS_PER_BYTE) begin
						r_next.bitcnt = 4'h0;
						if (r_reg.state == esb_pkg::ESB_ADDR) begin
							if (addr_match && !r_reg.busy) begin
								r_next.sda_oe = 1'b1;
								r_next.rw     = r_reg.shreg[`ESB_RW_BIT];
								r_next.state  = esb_pkg::ESB_ADDR_ACK;
							end else begin
								r_next.state = esb_pkg::ESB_IGNORE;
							end
						end else if (r_reg.state == esb_pkg::ESB_WADDR) begin
							r_next.waddr  = r_reg.shreg;
							r_next.sda_oe = 1'b1;
							r_next.state  = esb_pkg::ESB_WADDR_ACK;
						end else if (r_reg.nbytes < `ESB_PAGE_BYTES && fifo_ready) begin
							r_next.push   = 1'b1;
							r_next.nbytes = r_reg.nbytes + 4'h1;
							r_next.sda_oe = 1'b1;
							r_next.state  = esb_pkg::ESB_WDATA_ACK;
						end else begin
							// Ninth byte spoils the whole page
							r_next.ovf   = 1'b1;
							r_next.state = esb_pkg::ESB_IGNORE;
						end
					end
				end
				esb_pkg::ESB_ADDR_ACK: begin
					if (scl_fall) begin
						if (r_reg.rw) begin
							r_next.shreg  = esb_decode(r_reg.mem[r_reg.waddr]);
							r_next.sda_oe = ~r_next.shreg[7];
							r_next.state  = esb_pkg::ESB_RDATA;
						end else begin
							r_next.sda_oe = 1'b0;
							r_next.state  = esb_pkg::ESB_WADDR;
						end
					end
				end
				esb_pkg::ESB_WADDR_ACK: begin
					if (scl_fall) begin
						r_next.sda_oe = 1'b0;
						r_next.state  = esb_pkg::ESB_WDATA;
					end
				end
				esb_pkg::ESB_WDATA_ACK: begin
					if (scl_fall) begin
						r_next.waddr  = {r_reg.waddr[7:3], r_reg.waddr[2:0] + 3'h1};
						r_next.sda_oe = 1'b0;
						r_next.state  = esb_pkg::ESB_WDATA;
					end
				end
				esb_pkg::ESB_RDATA: begin
					if (scl_rise) begin
						r_next.bitcnt = r_reg.bitcnt + 4'h1;
					end else if (scl_fall) begin
						if (r_reg.bitcnt == `ESB_BITS_PER_BYTE) begin
							r_next.bitcnt = 4'h0;
							r_next.sda_oe = 1'b0;
							r_next.waddr  = r_reg.waddr + 8'h01;
							r_next.state  = esb_pkg::ESB_RACK;
						end else begin
							r_next.shreg  = {r_reg.shreg[6:0], 1'b0};
							r_next.sda_oe = ~r_reg.shreg[6];
						end
					end
				end
				esb_pkg::ESB_RACK: begin
					if (scl_rise) begin
						r_next.mack = ~r_reg.sda_s;
					end else if (scl_fall) begin
						// Master nack ends the read, bus left high
						if (r_reg.mack) begin
							r_next.shreg  = esb_decode(r_reg.mem[r_reg.waddr]);
							r_next.sda_oe = ~r_next.shreg[7];
							r_next.state  = esb_pkg::ESB_RDATA;
						end else begin
							r_next.state = esb_pkg::ESB_IGNORE;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign SDA_O   = 1'b0;
	assign SDA_OE  = r_reg.sda_oe;
	assign EW_BUSY = r_reg.busy;

endmodule : esb_serial_eeprom_bus_slave

// *** tb/esb_props.sv ***
`timescale 1ns/1ps
// ====================
// Port checker
module esb_props #(
	parameter int unsigned EW_BYTE_CYCLES = 100000
) (
	input wire logic CLK_SYS,
	input wire logic SRST,
	input wire logic SCL,
	input wire logic SDA_I,
	input wire logic SDA_O,
	input wire logic SDA_OE,
	input wire logic CHIP_SELECT_BIT0,
	input wire logic CHIP_SELECT_BIT1,
	input wire logic CHIP_SELECT_BIT2,
	input wire logic PROG_TIMING_PIN,
	input wire logic EW_BUSY
);
	logic [3:0]  bc;
	logic [7:0]  sh;
	logic [7:0]  stp;
	int unsigned run;
	wire  [6:0]  me = {4'hA, CHIP_SELECT_BIT2, CHIP_SELECT_BIT1, CHIP_SELECT_BIT0};
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (SRST);
	sequence s_start;
		SCL && $fell(SDA_I);
	endsequence
	sequence s_quiet;
		!SDA_OE [*8];
	endsequence
	// First byte tracker, raw bus view
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			bc <= 4'h9;
		end else if (SCL && $fell(SDA_I)) begin
			bc <= 4'h0;
		end else if ($rose(SCL) && bc != 4'h9) begin
			bc <= bc + 4'h1;
		end
		if ($rose(SCL)) begin
			sh <= {sh[6:0], SDA_I};
		end
		if (SRST || (SCL && $changed(SDA_I))) begin
			stp <= 8'h00;
		end else if (stp != 8'hFF) begin
			stp <= stp + 8'h01;
		end
		run <= EW_BUSY ? run + 1 : 0;
	end
	chk_reset_idle: assert property (disable iff (1'b0) SRST |=> !SDA_OE && !EW_BUSY)
		else $error("outputs not idle after reset");
	chk_addr_quiet: assert property (s_start |=> s_quiet)
		else $error("data line driven during address");
	chk_addr_ack: assert property ($fell(SCL) && bc == 4'h8 && sh[7:1] == me && !EW_BUSY |-> ##[1:6] SDA_OE)
		else $error("own address not acknowledged");
	chk_addr_refuse: assert property (bc == 4'h8 && sh[7:1] != me |-> !SDA_OE)
		else $error("foreign address acknowledged");
	chk_busy_deaf: assert property (EW_BUSY |-> !SDA_OE)
		else $error("acknowledge while programming");
	chk_busy_len: assert property ($fell(EW_BUSY) |-> run >= EW_BYTE_CYCLES - 1)
		else $error("programming cycle too short");
	chk_busy_start: assert property ($rose(EW_BUSY) |-> stp <= 8'h08)
		else $error("programming began mid transfer");
	chk_oe_scl_low: assert property ($changed(SDA_OE) |-> !SCL)
		else $error("data line moved while clock high");
	chk_oe_hold: assert property ($rose(SDA_OE) |-> SDA_OE [*5])
		else $error("driven bit too short");
	chk_drive_low: assert property (SDA_OE |-> !SDA_O)
		else $error("data line driven high");
endmodule : esb_props

// *** tb/esb_i2c_master.sv ***
`timescale 1ns/1ps
// ====================
// Bus master model
module esb_i2c_master (
	input  wire logic clk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_m
);
	logic sda_q;
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	// Sample away from the edge to avoid races
	always @(negedge clk) sda_q <= sda;
	task automatic st(input logic c, input logic d);
		scl <= c;
		sda_m <= d;
		repeat (2) @(posedge clk);
	endtask : st
	task automatic start;
		st(1'b0, sda_m);
		st(1'b0, 1'b1);
		st(1'b1, 1'b1);
		st(1'b1, 1'b0);
	endtask : start
	task automatic stop;
		st(1'b0, sda_m);
		st(1'b0, 1'b0);
		st(1'b1, 1'b0);
		st(1'b1, 1'b1);
	endtask : stop
	task automatic bit_x(input logic b, output logic r);
		st(1'b0, sda_m);
		st(1'b0, b);
		st(1'b1, b);
		st(1'b1, b);
		r = sda_q;
	endtask : bit_x
	task automatic wb(input logic [7:0] d, output logic ak);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(d[i], r);
		bit_x(1'b1, ak);
	endtask : wb
	task automatic rbyte(input logic nak, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, r);
			d[i] = r;
		end
		bit_x(nak, r);
	endtask : rbyte
endmodule : esb_i2c_master

// *** tb/tb_serial_eeprom_bus_slave.sv ***
`timescale 1ns/1ps
// ====================
// Bench
module tb_serial_eeprom_bus_slave;
	localparam int unsigned EW = 200;
	logic       clk = 1'b0;
	logic       srst = 1'b1;
	logic       prg = 1'b1;
	logic [2:0] cs = 3'h5;
	logic [7:0] rb [8];
	logic       ak;
	int         num_errors = 0;
	int         n_tests = 0;
	wire        scl;
	wire        sda_m;
	wire        oe;
	wire        busy;
	wire        sdo;
	// Pulled-up wire, either party pulls low
	wire        sda = sda_m & (oe ? sdo : 1'b1);
	always #50 clk = ~clk;
	esb_serial_eeprom_bus_slave #(.EW_BYTE_CYCLES(EW)) DUT (
		.CLK_SYS(clk), .SRST(srst), .SCL(scl), .SDA_I(sda), .SDA_O(sdo), .SDA_OE(oe),
		.CHIP_SELECT_BIT0(cs[0]), .CHIP_SELECT_BIT1(cs[1]), .CHIP_SELECT_BIT2(cs[2]),
		.PROG_TIMING_PIN(prg), .EW_BUSY(busy));
	esb_i2c_master m (.clk(clk), .sda(sda), .scl(scl), .sda_m(sda_m));
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	task automatic wt(input logic exp);
		int k;
		for (k = 0; k < 40 && !busy; k++) @(posedge clk);
		cmp(busy, exp);
		for (k = 0; k < 4000 && busy; k++) @(posedge clk);
		cmp(busy, 1'b0);
	endtask : wt
	task automatic wr(input logic [7:0] a, input int n, input logic [7:0] d0);
		m.start();
		m.wb({4'hA, cs, 1'b0}, ak);
		cmp(ak, 1'b0);
		m.wb(a, ak);
		cmp(ak, 1'b0);
		for (int i = 0; i < n; i++) begin
			m.wb(d0 + 8'(i), ak);
			cmp(ak, i >= 8);
		end
		m.stop();
	endtask : wr
	task automatic rd(input logic [7:0] a, input int n);
		m.start();
		m.wb({4'hA, cs, 1'b0}, ak);
		m.wb(a, ak);
		m.start();
		m.wb({4'hA, cs, 1'b1}, ak);
		cmp(ak, 1'b0);
		for (int i = 0; i < n; i++) m.rbyte(i == n - 1, rb[i]);
		m.stop();
	endtask : rd
	task automatic t_basic;
		wr(8'h10, 1, 8'h5A);
		wt(1'b1);
		rd(8'h10, 1);
		cmp(rb[0], 8'h5A);
		$display("t_basic done");
	endtask : t_basic
	task automatic t_page;
		wr(8'h1D, 8, 8'h30);
		wt(1'b1);
		rd(8'h18, 8);
		for (int j = 0; j < 8; j++) cmp(rb[j], 8'h30 + 8'((j + 3) & 7));
		$display("t_page done");
	endtask : t_page
	task automatic t_over;
		wr(8'h1D, 9, 8'h80);
		wt(1'b0);
		rd(8'h1D, 1);
		cmp(rb[0], 8'h30);
		// Current-address read carries on after the last read
		m.start();
		m.wb({4'hA, cs, 1'b1}, ak);
		cmp(ak, 1'b0);
		m.rbyte(1'b1, rb[1]);
		m.stop();
		cmp(rb[1], 8'h31);
		$display("t_over done");
	endtask : t_over
	task automatic t_busy;
		wr(8'h20, 2, 8'h11);
		m.start();
		m.wb({4'hA, cs, 1'b0}, ak);
		cmp(ak, 1'b1);
		m.stop();
		wt(1'b1);
		$display("t_busy done");
	endtask : t_busy
	task automatic t_sel;
		logic [7:0] code;
		logic       nm;
		// every strap seen at both levels
		for (int s = 0; s < 2; s++) begin
			cs <= (s == 0) ? 3'h5 : 3'h2;
			repeat (4) @(posedge clk);
			for (int i = 0; i < 9; i++) begin
				code = (i < 8) ? {4'hA, 3'(i), 1'b0} : {4'h5, cs, 1'b0};
				nm = (code[3:1] != cs) || (i == 8);
				m.start();
				m.wb(code, ak);
				cmp(ak, nm);
				m.wb(8'h00, ak);
				cmp(ak, nm);
				m.stop();
			end
		end
		$display("t_sel done");
	endtask : t_sel
	task automatic t_ext;
		prg <= 1'b0;
		repeat (4) @(posedge clk);
		prg <= 1'b1;
		wr(8'h60, 1, 8'hC3);
		repeat (300) @(posedge clk);
		cmp(busy, 1'b1);
		prg <= 1'b0;
		repeat (4) @(posedge clk);
		prg <= 1'b1;
		wt(1'b1);
		rd(8'h60, 1);
		cmp(rb[0], 8'hC3);
		$display("t_ext done");
	endtask : t_ext
	task automatic final_report;
		$display("tests %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : final_report
	initial begin
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		repeat (8) @(posedge clk);
		t_basic();
		t_page();
		t_over();
		t_busy();
		t_sel();
		// External timing is sticky, so it runs last
		t_ext();
		final_report();
	end
	initial begin
		repeat (60000) @(posedge clk);
		num_errors++;
		final_report();
	end
endmodule : tb_serial_eeprom_bus_slave

bind esb_serial_eeprom_bus_slave esb_props #(.EW_BYTE_CYCLES(EW_BYTE_CYCLES)) u_props (
	.CLK_SYS, .SRST, .SCL, .SDA_I, .SDA_O, .SDA_OE, .CHIP_SELECT_BIT0, .CHIP_SELECT_BIT1,
	.CHIP_SELECT_BIT2, .PROG_TIMING_PIN, .EW_BUSY);
